// file: design/fdr_pkg.sv
// Constants, types and the register map for the fan duty ramp limiter.
// Assumes a 20 MHz core clock and a byte-wide register port.
package fdr_pkg;
   // ==========================================================
   // Register map
   localparam logic [7:0] FDR_RAMP_CTRL1_ADDR = 8'h62;
   localparam logic [7:0] FDR_RAMP_CTRL1_RST = 8'h00;
   localparam int FDR_RATE_LSB = 0;
   localparam int FDR_RATE_MSB = 2;
   localparam logic [7:0] FDR_UNMAPPED_READ = 8'h00;

   // ==========================================================
   // Timing: full 0 to 100 percent sweep at step 1, and the clock rate
   localparam longint FDR_CLK_HZ = 20000000;
   localparam longint FDR_FULL_SWEEP_T0_MS = 37500;
   localparam longint FDR_FULL_SWEEP_T1_MS = 52200;
   localparam longint FDR_DUTY_FULL_SCALE = 255;
   // One unit step per interval, so the interval is sweep time over full scale
   localparam int FDR_INTERVAL_T0_CYC = int'(FDR_FULL_SWEEP_T0_MS * (FDR_CLK_HZ / 1000) / FDR_DUTY_FULL_SCALE);
   localparam int FDR_INTERVAL_T1_CYC = int'(FDR_FULL_SWEEP_T1_MS * (FDR_CLK_HZ / 1000) / FDR_DUTY_FULL_SCALE);

   // ==========================================================
   // Types
   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } fdr_req_s;

   typedef enum logic [1:0] {
      FDR_HOLD = 2'b01,
      FDR_RAMP = 2'b10
   } fdr_state_e;

   // Step size for each rate code
   function automatic logic [7:0] fdr_step(input logic [2:0] code);
      logic [7:0] s;
      s = 8'h01;
      case (code)
         3'h0: s = 8'h01;
         3'h1: s = 8'h02;
         3'h2: s = 8'h03;
         3'h3: s = 8'h04;
         3'h4: s = 8'h08;
         3'h5: s = 8'h0C;
         3'h6: s = 8'h18;
         3'h7: s = 8'h30;
         default: s = 8'h01;
      endcase
      return s;
   endfunction
endpackage

// file: design/fdr_ramp_limiter.sv
// Fan duty ramp limiter: register 0x62 and the slewed duty output.
// Assumes the lock bit and the table-select bit come from other registers
// of the device as synchronous levels, and the automatic loop supplies a target.
// Operation
// - While the lock input is set, writes to the ramp control register are ignored.
// - The ramp control register at 0x62 loads 0x00 at power-on reset.
// - Bits 2 to 0 of the register set the maximum rate of change of the remote 1 duty.
// - A new target duty is approached gradually rather than taken at once.
// - With the table bit clear, codes 0 to 7 give steps 1,2,3,4,8,12,24,48 over a 37.5 s base sweep.
// - With the table bit set, the same codes use the second, slower ramp time table.
`timescale 1ns/1ps
module fdr_ramp_limiter
   import fdr_pkg::*;
#(
   parameter int INTERVAL_T0_CYC = FDR_INTERVAL_T0_CYC,
   parameter int INTERVAL_T1_CYC = FDR_INTERVAL_T1_CYC
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // Register port
   input wire fdr_req_s req_i,
   output logic [7:0] rdata_o,
   // Settings held in other registers
   input wire logic lock_i,
   input wire logic alt_table_i,
   // Duty path
   input wire logic [7:0] target_duty_i,
   output logic [7:0] duty_o,
   output logic ramping_o
);
   // ==========================================================
   // Register file
   logic [7:0] ramp_ctrl_reg, ramp_ctrl_next;
   logic [7:0] rdata_reg, rdata_next;
   logic [2:0] remote1_ramp_rate;

   // Write only when unlocked; reads are registered, unmapped reads give zero
   always_comb begin
      ramp_ctrl_next = ramp_ctrl_reg;
      if (req_i.wr && !lock_i && req_i.addr == FDR_RAMP_CTRL1_ADDR) begin
         ramp_ctrl_next = req_i.wdata;
      end
      rdata_next = (req_i.addr == FDR_RAMP_CTRL1_ADDR) ? ramp_ctrl_reg : FDR_UNMAPPED_READ;
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ramp_ctrl_reg <= FDR_RAMP_CTRL1_RST;
         rdata_reg <= FDR_UNMAPPED_READ;
      end else begin
         ramp_ctrl_reg <= ramp_ctrl_next;
         rdata_reg <= rdata_next;
      end
   end

   assign remote1_ramp_rate = ramp_ctrl_reg[FDR_RATE_MSB:FDR_RATE_LSB];
   assign rdata_o = rdata_reg;

   // ==========================================================
   // Update interval timer
   // The counter runs free from reset and is not restarted by a new target,
   // so the first step after a target change lands within one full interval.
   // That costs up to one interval of latency but keeps the timer independent of the loop.
   logic [31:0] tick_cnt_reg, tick_cnt_next;
   logic [31:0] interval_lim;
   logic tick;

   // Compare with >= so a table switch mid-count cannot strand the counter
   assign interval_lim = alt_table_i ? 32'(INTERVAL_T1_CYC - 1) : 32'(INTERVAL_T0_CYC - 1);
   assign tick = (tick_cnt_reg >= interval_lim);

   always_comb begin
      tick_cnt_next = tick ? 32'h0 : tick_cnt_reg + 32'h1;
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tick_cnt_reg <= 32'h0;
      end else begin
         tick_cnt_reg <= tick_cnt_next;
      end
   end

   // ==========================================================
   // Duty slew state machine
   // HOLD waits for a target that differs from the duty; RAMP moves only on ticks.
   // A target that moves during a ramp is followed from the present duty, never restarted.
   fdr_state_e state_reg, state_next;
   logic [7:0] duty_reg, duty_next;
   logic [7:0] step;
   logic [7:0] gap;

   assign step = fdr_step(remote1_ramp_rate);
   assign gap = (duty_reg < target_duty_i) ? target_duty_i - duty_reg : duty_reg - target_duty_i;

   // Moves one step per tick; the last move is trimmed to land exactly on target
   always_comb begin
      state_next = state_reg;
      duty_next = duty_reg;
      case (state_reg)
         FDR_HOLD: begin
            if (duty_reg != target_duty_i) begin
               state_next = FDR_RAMP;
            end
         end
         FDR_RAMP: begin
            if (duty_reg == target_duty_i) begin
               state_next = FDR_HOLD;
            end else if (tick) begin
               if (duty_reg < target_duty_i) begin
                  duty_next = (gap > step) ? duty_reg + step : target_duty_i;
               end else begin
                  duty_next = (gap > step) ? duty_reg - step : target_duty_i;
               end
            end
         end
         default: begin
            state_next = FDR_HOLD;
         end
      endcase
   end

   // Duty starts at zero; the fan loop is expected to drive its own start-up
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg <= FDR_HOLD;
         duty_reg <= 8'h00;
      end else begin
         state_reg <= state_next;
         duty_reg <= duty_next;
      end
   end

   assign duty_o = duty_reg;
   assign ramping_o = (state_reg == FDR_RAMP);

   // ==========================================================
   // Assertions
   // All checks share the core clock and are switched off while reset is low.
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);

   // Register port
   a_lock_blocks_write: assert property (
      req_i.wr && lock_i && req_i.addr == FDR_RAMP_CTRL1_ADDR |=> $stable(ramp_ctrl_reg))
      else $error("locked write changed the ramp register");

   a_write_updates_reg: assert property (
      req_i.wr && !lock_i && req_i.addr == FDR_RAMP_CTRL1_ADDR |=> ramp_ctrl_reg == $past(req_i.wdata))
      else $error("unlocked write not stored");

   a_read_returns_reg: assert property (
      req_i.addr == FDR_RAMP_CTRL1_ADDR && !req_i.wr |=> rdata_o == ramp_ctrl_reg)
      else $error("read data mismatch");

   a_unmapped_reads_zero: assert property (
      req_i.addr != FDR_RAMP_CTRL1_ADDR |=> rdata_o == FDR_UNMAPPED_READ)
      else $error("unmapped read not zero");

   a_read_after_write: assert property (
      req_i.wr && !lock_i && req_i.addr == FDR_RAMP_CTRL1_ADDR ##1 !req_i.wr && req_i.addr == FDR_RAMP_CTRL1_ADDR
      |=> rdata_o == $past(req_i.wdata, 2))
      else $error("written value not read back");

   // Duty slew
   a_no_jump_between: assert property (
      !tick |=> $stable(duty_reg))
      else $error("duty moved without an interval tick");

   a_step_size_up: assert property (
      state_reg == FDR_RAMP && tick && duty_reg < target_duty_i && gap > step
      |=> duty_reg == $past(duty_reg) + $past(step))
      else $error("upward step size wrong");

   a_step_size_down: assert property (
      state_reg == FDR_RAMP && tick && duty_reg > target_duty_i && gap > step
      |=> duty_reg == $past(duty_reg) - $past(step))
      else $error("downward step size wrong");

   a_clamp_at_target: assert property (
      state_reg == FDR_RAMP && tick && duty_reg != target_duty_i && gap <= step
      |=> duty_reg == $past(target_duty_i))
      else $error("final step did not land on target");

   a_hold_to_ramp: assert property (
      state_reg == FDR_HOLD && duty_reg != target_duty_i |=> state_reg == FDR_RAMP)
      else $error("hold state ignored a new target");

   a_ramp_exits_on_target: assert property (
      state_reg == FDR_RAMP && duty_reg == target_duty_i |=> state_reg == FDR_HOLD)
      else $error("ramp state kept after reaching target");

   a_hold_keeps_duty: assert property (
      state_reg == FDR_HOLD |=> $stable(duty_reg))
      else $error("duty moved while holding");

   a_no_overshoot_up: assert property (
      state_reg == FDR_RAMP && tick && duty_reg < target_duty_i
      |=> duty_reg <= $past(target_duty_i))
      else $error("upward move passed the target");

   a_no_overshoot_down: assert property (
      state_reg == FDR_RAMP && tick && duty_reg > target_duty_i
      |=> duty_reg >= $past(target_duty_i))
      else $error("downward move passed the target");

   a_state_one_hot: assert property ($onehot(state_reg))
      else $error("slew state is not one-hot");

   // Interval timer
   a_tick_restarts: assert property (
      tick |=> tick_cnt_reg == 32'h0)
      else $error("interval counter did not restart after a tick");

   // A table switch mid-count may leave the counter up to the longer limit, never past it
   a_count_bounded: assert property (
      tick_cnt_reg <= 32'(((INTERVAL_T0_CYC > INTERVAL_T1_CYC) ? INTERVAL_T0_CYC : INTERVAL_T1_CYC) - 1))
      else $error("interval counter ran past its limit");

   // Main scenarios

   c_ramp_up: cover property (state_reg == FDR_RAMP && tick && duty_reg < target_duty_i);
   c_ramp_down: cover property (state_reg == FDR_RAMP && tick && duty_reg > target_duty_i);
   c_locked_write: cover property (req_i.wr && lock_i && req_i.addr == FDR_RAMP_CTRL1_ADDR);
   c_alt_table_tick: cover property (alt_table_i && tick);
   c_clamp_landing: cover property (state_reg == FDR_RAMP && tick && duty_reg != target_duty_i && gap <= step);
endmodule

// file: sim/fdr_fan_model.sv
// Fan model driven by the slewed duty output.
// Assumes the duty is a full-scale 255 byte.
`timescale 1ns/1ps
module fdr_fan_model (
   // Clock and drive
   input wire logic core_clk_i,
   input wire logic [7:0] duty_i,
   // Observed speed
   output logic [7:0] speed_o
);
   // Inertia: speed creeps one unit per clock, so a jump would show as lag
   logic [7:0] speed_reg = 8'h00;
   always @(posedge core_clk_i) begin
      if (speed_reg < duty_i) speed_reg <= speed_reg + 8'h01;
      else if (speed_reg > duty_i) speed_reg <= speed_reg - 8'h01;
   end
   assign speed_o = speed_reg;
endmodule

// file: sim/fdr_ramp_limiter_tb.sv
// Self-checking bench for the fan duty ramp limiter.
// Assumes short tick intervals of 4 and 6 cycles on the design.
`timescale 1ns/1ps
module fdr_ramp_limiter_tb;
   import fdr_pkg::*;
   typedef struct packed {logic [2:0] code; logic alt; logic [7:0] step;} fdr_row_s;
   logic core_clk_i, rst_n_i, lock_i, alt_table_i, ramping_o;
   fdr_req_s req_i;
   logic [7:0] rdata_o, target_duty_i, duty_o, speed, d;
   int n_mismatch = 0, check_count = 0, gap;
   // Rate code, table select and the step it must give
   fdr_row_s rows [10] = '{{3'h0, 1'b0, 8'h01}, {3'h1, 1'b0, 8'h02}, {3'h2, 1'b0, 8'h03},
      {3'h3, 1'b0, 8'h04}, {3'h4, 1'b0, 8'h08}, {3'h5, 1'b0, 8'h0C}, {3'h6, 1'b0, 8'h18},
      {3'h7, 1'b0, 8'h30}, {3'h0, 1'b1, 8'h01}, {3'h7, 1'b1, 8'h30}};
   fdr_ramp_limiter #(.INTERVAL_T0_CYC(4), .INTERVAL_T1_CYC(6)) fdr_ramp_limiter_i (.core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i), .req_i(req_i), .rdata_o(rdata_o), .lock_i(lock_i), .alt_table_i(alt_table_i),
      .target_duty_i(target_duty_i), .duty_o(duty_o), .ramping_o(ramping_o));
   fdr_fan_model fdr_fan_model_i (.core_clk_i(core_clk_i), .duty_i(duty_o), .speed_o(speed));
   // ====
   // Tasks: all entered at a falling edge
   initial begin
      core_clk_i = 1'b0;
      forever #25 core_clk_i = ~core_clk_i;
   end
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
      req_i = '{1'b1, a, v};
      @(negedge core_clk_i);
      req_i.wr = 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a);
      req_i.addr = a;
      @(negedge core_clk_i);
      d = rdata_o;
   endtask
   // Bounded wait until the output rests on the target
   task automatic settle(input logic [7:0] t);
      target_duty_i = t;
      @(negedge core_clk_i);
      for (int k = 0; k < 2000 && ramping_o !== 1'b0; k++) @(negedge core_clk_i);
      check("ramp finished", {7'h00, ramping_o}, 8'h00);
   endtask
   // First duty after a new target, then cycles to the next step
   task automatic step_run(input logic [7:0] t);
      logic [7:0] d0;
      d0 = duty_o;
      target_duty_i = t;
      gap = 0;
      for (int k = 0; k < 100 && duty_o === d0; k++) @(negedge core_clk_i);
      d = duty_o;
      while (gap < 100 && duty_o === d) begin
         @(negedge core_clk_i);
         gap++;
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Watchdog: 20000 cycles, several times what the run needs
   initial begin
      #1000000;
      n_mismatch++;
      conclude();
   end
   // ====
   // Main sequence
   initial begin
      req_i = '0;
      lock_i = 1'b0;
      alt_table_i = 1'b0;
      target_duty_i = 8'h00;
      rst_n_i = 1'b0;
      repeat (4) @(negedge core_clk_i);
      rst_n_i = 1'b1;
      rd_reg(FDR_RAMP_CTRL1_ADDR);
      check("reset value", d, 8'h00);
      foreach (rows[r]) begin
         alt_table_i = rows[r].alt;
         settle(8'h00);
         wr_reg(FDR_RAMP_CTRL1_ADDR, {5'h00, rows[r].code});
         rd_reg(FDR_RAMP_CTRL1_ADDR);
         check("rate field", d, {5'h00, rows[r].code});
         step_run(8'h64);
         check("first step", d, rows[r].step);
         check("interval", gap[7:0], rows[r].alt ? 8'h06 : 8'h04);
         settle(8'h64);
         check("clamped duty", duty_o, 8'h64);
      end
      repeat (120) @(negedge core_clk_i);
      check("fan speed", speed, 8'h64);
      // Locked write and an unmapped place
      lock_i = 1'b1;
      wr_reg(FDR_RAMP_CTRL1_ADDR, 8'h05);
      rd_reg(FDR_RAMP_CTRL1_ADDR);
      check("locked reg", d, 8'h07);
      lock_i = 1'b0;
      wr_reg(8'h63, 8'h02);
      rd_reg(8'h63);
      check("unmapped", d, 8'h00);
      rd_reg(FDR_RAMP_CTRL1_ADDR);
      check("reg kept", d, 8'h07);
      // Reset in mid ramp
      target_duty_i = 8'h00;
      repeat (3) @(negedge core_clk_i);
      rst_n_i = 1'b0;
      @(negedge core_clk_i);
      check("duty in reset", duty_o, 8'h00);
      check("ramping in reset", {7'h00, ramping_o}, 8'h00);
      rst_n_i = 1'b1;
      rd_reg(FDR_RAMP_CTRL1_ADDR);
      check("reg after reset", d, 8'h00);
      conclude();
   end
endmodule
